// ---- shared/art_pkg.sv ----
`default_nettype none
package art_pkg;
    // Register indices (printed offsets are not all multiples of four)
    localparam logic [7:0] IDX_CTRL_B  = 8'h03;
    localparam logic [7:0] IDX_RES_LO  = 8'h04;
    localparam logic [7:0] IDX_RES_HI  = 8'h05;
    localparam logic [7:0] IDX_DIDIS   = 8'h14;
    localparam logic [7:0] IDX_CTRL_A  = 8'h20;
    localparam logic [7:0] IDX_MUX     = 8'h21;
    localparam logic [7:0] IDX_CONV    = 8'h22;
    localparam logic [7:0] IDX_PINS    = 8'h23;
    // Control B fields
    localparam int CB_BIPOLAR   = 7;
    localparam int CB_CMP_MUX   = 6;
    localparam int CB_POL_REV   = 5;
    localparam logic [7:0] CB_WMASK = 8'he7;
    // Control A fields
    localparam int CA_ENABLE    = 7;
    localparam int CA_START     = 6;
    localparam int CA_AUTO      = 5;
    localparam int CA_DONE      = 4;
    localparam logic [7:0] CA_WMASK = 8'hef;
    // Mux register fields
    localparam int MX_LEFT      = 5;
    localparam logic [3:0] CH_TEMP = 4'hf;
    localparam logic [7:0] DIDIS_WMASK = 8'hff;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Conversion time in clock cycles, stand-in for the analog core
    localparam int CONV_CYCLES = 13;
    // Trigger source codes
    typedef enum logic [2:0] {
        ART_TRG_FREE = 3'h0,
        ART_TRG_CMP  = 3'h1,
        ART_TRG_INT0 = 3'h2,
        ART_TRG_CMPA = 3'h3,
        ART_TRG_OVF  = 3'h4,
        ART_TRG_CMPB = 3'h5,
        ART_TRG_PCI  = 3'h6,
        ART_TRG_NONE = 3'h7
    } art_trig_t;
    typedef struct packed {
        logic cmp;
        logic int0;
        logic cmpa;
        logic ovf;
        logic cmpb;
        logic pci;
    } art_flags_t;
    typedef enum logic [1:0] {
        ART_IDLE = 2'b01,
        ART_BUSY = 2'b10
    } art_state_t;
endpackage : art_pkg
`default_nettype wire

// ---- rtl/art_regs.sv ----
// Our own choice: register access over APB.
`default_nettype none
// Contract
// - Left align puts bits 9..2 high
// - Completion loads result, unused bits zero
// - Low byte read locks until high read
// - Bipolar gives signed nine bits plus sign
// - Unipolar negative difference saturates, no wrap
// - Polarity reverse swaps differential inputs
// - Control B bits 4:3 read zero
// - Trigger source only with auto enable
// - Switch to set flag is edge
// - Free running selection needs a software start, then restarts itself at each completion
// - Trigger codes 1 to 6 decode to six flag sources
// - Disable bit forces pin input zero
// - Channel 1111 selects and enables sensor
// - Alignment change shows immediately
// - Auto enable arms rising edge detector
// - Done flag set at completion
module art_regs
    import art_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Trigger flags from timers, comparator, interrupts
    input  wire art_flags_t  trig_flags_in,
    // Analog core: signed difference pos minus neg (11 bits)
    input  wire logic [10:0] diff_sample_in,
    input  wire logic [9:0]  single_sample_in,
    // Raw pin levels of analog pins 3..0 and comparator pins
    input  wire logic [5:0]  pin_raw_in,
    // Analog control outputs
    output logic             conv_busy_out,
    output logic             temp_sensor_en_out,
    output logic [3:0]       channel_select_out,
    output logic             polarity_reverse_out,
    output logic             comparator_mux_enable_out,
    output logic [5:0]       input_buffer_off_out,
    output logic [5:0]       pin_read_out
);
    initial begin
        if (CONV_CYC < 1 || CONV_CYC > 255) begin
            $error("CONV_CYC out of range");
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  ctrl_b;
    logic [7:0]  ctrl_a;
    logic [7:0]  mux_reg;
    logic [7:0]  didis;
    logic [9:0]  result;
    logic        locked;
    logic        trig_prev;
    logic [7:0]  cnt;
    logic [3:0]  conv_ch;
    art_state_t  state;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        acc     = psel_in & penable_in;
    wire [9:0]  idx     = paddr_in[11:2];
    wire        wr      = acc & pwrite_in;
    wire        rd      = acc & ~pwrite_in;
    wire [7:0]  wbyte   = pwdata_in[7:0];
    wire        hit_cb  = idx == {2'h0, IDX_CTRL_B};
    wire        hit_lo  = idx == {2'h0, IDX_RES_LO};
    wire        hit_hi  = idx == {2'h0, IDX_RES_HI};
    wire        hit_dd  = idx == {2'h0, IDX_DIDIS};
    wire        hit_ca  = idx == {2'h0, IDX_CTRL_A};
    wire        hit_mx  = idx == {2'h0, IDX_MUX};
    wire        hit_cv  = idx == {2'h0, IDX_CONV};
    wire        hit_pn  = idx == {2'h0, IDX_PINS};
    wire        mapped  = hit_cb | hit_lo | hit_hi | hit_dd | hit_ca
                        | hit_mx | hit_cv | hit_pn;

    // ------------------------------------------------------------
    // Result formatting
    // ------------------------------------------------------------
    wire        left    = mux_reg[MX_LEFT];
    // Alignment applied at read time so a change shows at once
    wire [7:0]  res_hi  = left ? result[9:2]
                               : {6'h00, result[9:8]};
    wire [7:0]  res_lo  = left ? {result[1:0], 6'h00}
                               : result[7:0];

    // Differential sample, reversed when asked
    wire [10:0] diff_eff = ctrl_b[CB_POL_REV]
                         ? 11'(~diff_sample_in + 11'h001)
                         : diff_sample_in;
    wire        diff_ch  = conv_ch[3:2] == 2'b01 || conv_ch[3:2] == 2'b10;

    function automatic logic [9:0] fmt_diff(input logic [10:0] d,
                                            input logic bip);
        logic [9:0] r;
        r = 10'h000;
        if (bip) begin
            // Two's complement, nine bits plus sign; clamp range
            if (!d[10] && d[9]) begin
                r = 10'h1ff;
            end else if (d[10] && !d[9]) begin
                r = 10'h200;
            end else begin
                r = d[9:0];
            end
        end else if (d[10]) begin
            r = 10'h3ff;
        end else begin
            r = d[9:0];
        end
        return r;
    endfunction : fmt_diff

    wire [9:0] new_result = diff_ch
                          ? fmt_diff(diff_eff, ctrl_b[CB_BIPOLAR])
                          : single_sample_in;

    // ------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------
    wire [2:0] tsel = ctrl_b[2:0];
    logic trig_sig;
    assign trig_sig = (tsel == ART_TRG_CMP)  ? trig_flags_in.cmp  :
                      (tsel == ART_TRG_INT0) ? trig_flags_in.int0 :
                      (tsel == ART_TRG_CMPA) ? trig_flags_in.cmpa :
                      (tsel == ART_TRG_OVF)  ? trig_flags_in.ovf  :
                      (tsel == ART_TRG_CMPB) ? trig_flags_in.cmpb :
                      (tsel == ART_TRG_PCI)  ? trig_flags_in.pci  :
                      1'b0;   // Free running and code 111
    // Level compare against previous selected level, so switching
    // to a set source is an edge too
    wire trig_edge = trig_sig & ~trig_prev;
    wire auto_on   = ctrl_a[CA_AUTO] & ctrl_a[CA_ENABLE];
    wire free_run  = tsel == ART_TRG_FREE;
    wire busy      = state == ART_BUSY;
    wire done_pls  = busy && cnt == 8'h01;
    wire start_sw  = wr & hit_ca & wbyte[CA_START] & wbyte[CA_ENABLE];
    wire start_tr  = auto_on & trig_edge;
    wire start_fr  = auto_on & free_run & done_pls;
    wire start     = ~busy & (start_sw | start_tr)
                   | start_fr;

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    art_state_t next_state;
    always_comb begin
        case (state)
            ART_IDLE: next_state = start ? ART_BUSY : ART_IDLE;
            ART_BUSY: begin
                if (!ctrl_a[CA_ENABLE]) begin
                    next_state = ART_IDLE;
                end else if (done_pls && !start_fr) begin
                    next_state = ART_IDLE;
                end else begin
                    next_state = ART_BUSY;
                end
            end
            default:  next_state = ART_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= ART_IDLE;
            cnt   <= 8'h00;
        end else begin
            state <= next_state;
            if (start) begin
                cnt <= 8'(CONV_CYC);
            end else if (busy && cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
        end
    end

    // Channel latched at conversion start
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            conv_ch   <= 4'h0;
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_sig;
            if (start) begin
                conv_ch <= mux_reg[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Result and read lock
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            result <= 10'h000;
            locked <= 1'b0;
        end else begin
            if (done_pls && !locked) begin
                result <= new_result;
            end
            if (rd && hit_hi) begin
                locked <= 1'b0;
            end else if (rd && hit_lo) begin
                locked <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_b  <= RST_BYTE;
            ctrl_a  <= RST_BYTE;
            mux_reg <= RST_BYTE;
            didis   <= RST_BYTE;
        end else begin
            if (wr && hit_cb) begin
                ctrl_b <= wbyte & CB_WMASK;
            end
            if (wr && hit_mx) begin
                mux_reg <= wbyte;
            end
            if (wr && hit_dd) begin
                didis <= wbyte & DIDIS_WMASK;
            end
            // Done flag: set wins over write-one-to-clear
            ctrl_a[CA_DONE] <= done_pls
                ? 1'b1
                : ctrl_a[CA_DONE] & ~(wr & hit_ca & wbyte[CA_DONE]);
            ctrl_a[CA_START] <= next_state == ART_BUSY;
            if (wr && hit_ca) begin
                ctrl_a[7]   <= wbyte[7];
                ctrl_a[5]   <= wbyte[5];
                ctrl_a[3:0] <= wbyte[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------
    wire [5:0] pins_masked = pin_raw_in & ~didis[5:0];
    wire [7:0] rd_byte =
          hit_cb ? (ctrl_b & CB_WMASK)
        : hit_lo ? res_lo
        : hit_hi ? res_hi
        : hit_dd ? didis
        : hit_ca ? ctrl_a
        : hit_mx ? mux_reg
        : hit_cv ? {7'h00, busy}
        : hit_pn ? {2'h0, pins_masked}
        : 8'h00;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prdata_out                <= 32'h0000_0000;
            pready_out                <= 1'b0;
            pslverr_out               <= 1'b0;
            conv_busy_out             <= 1'b0;
            temp_sensor_en_out        <= 1'b0;
            channel_select_out        <= 4'h0;
            polarity_reverse_out      <= 1'b0;
            comparator_mux_enable_out <= 1'b0;
            input_buffer_off_out      <= 6'h00;
            pin_read_out              <= 6'h00;
        end else begin
            // Registered answer: no wait states, ready in the first access cycle
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~mapped;
            if (psel_in && !penable_in && !pwrite_in) begin
                prdata_out <= {24'h000000, rd_byte};
            end
            conv_busy_out      <= next_state == ART_BUSY;
            temp_sensor_en_out <= mux_reg[3:0] == CH_TEMP;
            channel_select_out <= mux_reg[3:0];
            polarity_reverse_out      <= ctrl_b[CB_POL_REV];
            comparator_mux_enable_out <= ctrl_b[CB_CMP_MUX];
            input_buffer_off_out      <= didis[5:0];
            pin_read_out              <= pins_masked;
        end
    end
endmodule : art_regs
`default_nettype wire

// ---- tb/art_regs_properties.sv ----
`default_nettype none
module art_regs_properties
    import art_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES
) (
    // Clock, reset and bus
    input wire logic        clk_in,
    input wire logic        arst_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    // Pins and analog control
    input wire logic [5:0]  pin_raw_in,
    input wire logic        conv_busy_out,
    input wire logic        temp_sensor_en_out,
    input wire logic [3:0]  channel_select_out,
    input wire logic        polarity_reverse_out,
    input wire logic        comparator_mux_enable_out,
    input wire logic [5:0]  input_buffer_off_out,
    input wire logic [5:0]  pin_read_out
);
    // ------------------------------------------------------------
    // Bus decode and helpers
    // ------------------------------------------------------------
    logic [1:0] age;
    logic [7:0] busy_cnt;
    wire logic acc = psel_in && penable_in && pready_out;
    wire logic wr_b = acc && pwrite_in && paddr_in == {2'h0, IDX_CTRL_B, 2'h0};
    wire logic rd_b = acc && !pwrite_in && paddr_in == {2'h0, IDX_CTRL_B, 2'h0};
    wire logic wr_d = acc && pwrite_in && paddr_in == {2'h0, IDX_DIDIS, 2'h0};
    // Outputs are held at zero one edge past reset, so wait it out
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            age      <= 2'h0;
            busy_cnt <= 8'h00;
        end else begin
            age      <= (age == 2'h3) ? age : age + 2'h1;
            busy_cnt <= conv_busy_out ? busy_cnt + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_access;
        psel_in && penable_in;
    endsequence
    a_ready_access: assert property (s_setup ##1 s_access |-> pready_out)
        else $error("pready missing in first access cycle");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr_out |-> s_access and pready_out)
        else $error("pslverr outside an answer");
    a_ctrlb_rsvd: assert property (rd_b |-> prdata_out[4:3] == 2'h0)
        else $error("control B reserved bits not zero");
    a_cmp_mux_fwd: assert property (
        wr_b |-> ##2 comparator_mux_enable_out == $past(pwdata_in[6], 2))
        else $error("comparator mux enable not forwarded");
    a_pol_rev_fwd: assert property (
        wr_b |-> ##2 polarity_reverse_out == $past(pwdata_in[5], 2))
        else $error("polarity reverse not forwarded");
    a_buf_off_fwd: assert property (
        wr_d |-> ##2 input_buffer_off_out == $past(pwdata_in[5:0], 2))
        else $error("input buffer disable not forwarded");
    a_pin_masked: assert property (
        age == 2'h3 && $stable(input_buffer_off_out) |->
        pin_read_out == ($past(pin_raw_in) & ~input_buffer_off_out))
        else $error("pin read not masked by disable");
    a_temp_sensor: assert property (
        temp_sensor_en_out == (channel_select_out == CH_TEMP))
        else $error("sensor enable disagrees with channel");
    a_busy_bounded: assert property (busy_cnt <= CONV_CYC + 2)
        else $error("conversion never completes");
endmodule : art_regs_properties
bind art_regs art_regs_properties #(.CONV_CYC(CONV_CYC)) u_props (
    .clk_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .pin_raw_in,
    .conv_busy_out, .temp_sensor_en_out, .channel_select_out,
    .polarity_reverse_out, .comparator_mux_enable_out,
    .input_buffer_off_out, .pin_read_out
);
`default_nettype wire

// ---- tb/test_art_regs.sv ----
`default_nettype none
module test_art_regs
    import art_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 1'b0, arst_n_in = 1'b0;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd, rnd;
    logic        pready_out, pslverr_out, conv_busy_out, err;
    logic        temp_sensor_en_out, polarity_reverse_out;
    logic        comparator_mux_enable_out;
    logic [3:0]  channel_select_out;
    logic [5:0]  pin_raw_in = 6'h00, input_buffer_off_out, pin_read_out;
    logic [10:0] diff_sample_in = 11'h000, d;
    logic [9:0]  single_sample_in = 10'h000, e;
    logic [7:0]  b;
    art_flags_t  trig_flags_in = '0;
    integer      seed = 32'h72ff;
    int          fails = 0, comparisons = 0, cyc = 0;
    logic [7:0]  idxs [5] = '{IDX_CTRL_B, IDX_RES_LO, IDX_RES_HI, IDX_DIDIS,
                              8'h10};
    always #50 clk_in = ~clk_in;
    art_regs #(.CONV_CYC(3)) dut_u (
        .clk_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .trig_flags_in,
        .diff_sample_in, .single_sample_in, .pin_raw_in, .conv_busy_out,
        .temp_sensor_en_out, .channel_select_out, .polarity_reverse_out,
        .comparator_mux_enable_out, .input_buffer_off_out, .pin_read_out
    );
    // ------------------------------------------------------------
    // Bus, checking and expectation helpers
    // ------------------------------------------------------------
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic check(string n, logic [31:0] x, logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask : check
    // Entered just after an edge; leaves one idle edge behind it
    task automatic apb(logic w, logic [7:0] i, logic [7:0] v);
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= {2'h0, i, 2'h0};
        pwdata_in <= {24'h0, v};
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd  = prdata_out;
        err = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask : apb
    task automatic conv(logic [7:0] cb, logic [7:0] m, logic [10:0] dv,
                        logic [9:0] sv);
        diff_sample_in   <= dv;
        single_sample_in <= sv;
        apb(1'b1, IDX_CTRL_B, cb);
        apb(1'b1, IDX_MUX, m);
        apb(1'b1, IDX_CTRL_A, 8'hc0);
        do @(posedge clk_in); while (conv_busy_out !== 1'b0);
        @(posedge clk_in);
    endtask : conv
    task automatic res(logic [9:0] v, logic left);
        apb(1'b0, IDX_RES_LO, 8'h00);
        check("res_lo", left ? {v[1:0], 6'h00} : v[7:0], rd);
        apb(1'b0, IDX_RES_HI, 8'h00);
        check("res_hi", left ? v[9:2] : {6'h00, v[9:8]}, rd);
    endtask : res
    task automatic busy_seen(logic x);
        logic s;
        s = 1'b0;
        repeat (5) begin
            @(posedge clk_in);
            s |= conv_busy_out === 1'b1;
        end
        check("busy", x, s);
    endtask : busy_seen
    function automatic logic [9:0] expect_res(logic [10:0] dv, logic [7:0] cb);
        int v;
        v = $signed(dv);
        if (cb[5]) v = -v;
        if (!cb[7] && v < 0) v = 1023;
        if (cb[7] && v > 511) v = 511;
        if (cb[7] && v < -512) v = -512;
        return v[9:0];
    endfunction : expect_res
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 5000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
        foreach (idxs[k]) begin
            apb(1'b0, idxs[k], 8'h00);
            check("reset_value", 32'h0, rd);
        end
        check("slverr", 32'h1, err);
        rnd = $random(seed);
        apb(1'b1, IDX_CTRL_B, rnd[7:0]);
        apb(1'b0, IDX_CTRL_B, 8'h00);
        check("ctrl_b", rnd[7:0] & 8'he7, rd);
        rnd = $random(seed);
        pin_raw_in <= rnd[13:8];
        apb(1'b1, IDX_DIDIS, rnd[7:0]);
        apb(1'b0, IDX_DIDIS, 8'h00);
        check("didis", rnd[7:0], rd);
        check("pins", rnd[13:8] & ~rnd[5:0], pin_read_out);
        apb(1'b0, IDX_PINS, 8'h00);
        check("pins_reg", rnd[13:8] & ~rnd[5:0], rd);
        for (int k = 14; k < 16; k++) begin
            apb(1'b1, IDX_MUX, k[7:0]);
            // Outputs follow the mux one edge after the write lands
            @(posedge clk_in);
            check("temp_en", k == 15, temp_sensor_en_out);
            check("channel", k, channel_select_out);
        end
        for (int k = 0; k < 8; k++) begin
            rnd = $random(seed);
            d = {k[2], rnd[9:1], 1'b1};
            b = {k[1], 1'b0, k[0], 5'h00};
            conv(b, 8'h06, d, 10'h000);
            res(expect_res(d, b), 1'b0);
        end
        rnd = $random(seed);
        conv(8'h00, 8'h20, 11'h000, rnd[9:0]);
        res(rnd[9:0], 1'b1);
        apb(1'b1, IDX_MUX, 8'h00);
        res(rnd[9:0], 1'b0);
        // Sensor channel is single ended: difference input is ignored
        rnd = $random(seed);
        conv(8'h00, 8'h0f, 11'h7ff, rnd[9:0]);
        res(rnd[9:0], 1'b0);
        apb(1'b0, IDX_CTRL_A, 8'h00);
        check("done_flag", 32'h1, rd[4]);
        apb(1'b0, IDX_RES_LO, 8'h00);
        conv(8'h00, 8'h00, 11'h000, ~rnd[9:0]);
        apb(1'b0, IDX_RES_HI, 8'h00);
        check("locked_hi", {6'h00, rnd[9:8]}, rd);
        apb(1'b1, IDX_CTRL_B, 8'h07);
        apb(1'b1, IDX_CTRL_A, 8'ha0);
        trig_flags_in <= '1;
        busy_seen(1'b0);
        trig_flags_in <= '0;
        apb(1'b1, IDX_CTRL_B, 8'h00);
        busy_seen(1'b0);
        for (int k = 1; k < 7; k++) begin
            apb(1'b1, IDX_CTRL_B, k[7:0]);
            trig_flags_in <= art_flags_t'(6'h20 >> (k - 1));
            busy_seen(1'b1);
            do @(posedge clk_in); while (conv_busy_out !== 1'b0);
            trig_flags_in <= '0;
        end
        trig_flags_in <= art_flags_t'(6'h10);
        apb(1'b1, IDX_CTRL_B, 8'h02);
        busy_seen(1'b1);
        do @(posedge clk_in); while (conv_busy_out !== 1'b0);
        // Drop the source first so the later rise is a real edge
        trig_flags_in <= '0;
        apb(1'b1, IDX_CTRL_A, 8'h80);
        trig_flags_in <= '1;
        busy_seen(1'b0);
        final_report();
    end
endmodule : test_art_regs
`default_nettype wire
